// File: design/asm_readout.sv
// Serial readout and mode selection of the converter digital interface
`default_nettype none
module asm_readout (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic CE,
    input wire logic SERIAL_CLK,
    input wire logic CONVERSION_START_INPUT,
    input wire logic SERIAL_SELECT_OR_CASCADE_IN,
    input wire logic [asm_pkg::DATA_W-1:0] ADC_CODE,
    input wire logic ADC_OVER,
    output logic SERIAL_RESULT_OUT,
    output logic SERIAL_RESULT_OE_N,
    output logic CONVERTING,
    output logic CS_MODE,
    output logic BUSY_EN
);
    import asm_pkg::*;

    function automatic logic [CNT_W-1:0] g2b(input logic [CNT_W-1:0] g);
        logic [CNT_W-1:0] b;
        b = g;
        for (int i = CNT_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : g2b

    // Link clock domain: edge counters and cascade capture
    logic [CNT_W-1:0] fall_bin_r;
    logic [CNT_W-1:0] fall_gray_r;
    logic [CNT_W-1:0] rise_bin_r;
    logic [CNT_W-1:0] rise_gray_r;
    logic casc_mem [0:(1<<CNT_W)-1];
    wire [CNT_W-1:0] fall_inc = fall_bin_r + 6'h01;
    wire [CNT_W-1:0] rise_inc = rise_bin_r + 6'h01;

    always_ff @(negedge SERIAL_CLK or negedge RSTN) begin
        if (!RSTN) begin
            fall_bin_r <= CNT_RST;
            fall_gray_r <= CNT_RST;
        end else begin
            fall_bin_r <= fall_inc;
            fall_gray_r <= fall_inc ^ (fall_inc >> 1);
        end
    end

    always_ff @(posedge SERIAL_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rise_bin_r <= CNT_RST;
            rise_gray_r <= CNT_RST;
        end else begin
            rise_bin_r <= rise_inc;
            rise_gray_r <= rise_inc ^ (rise_inc >> 1);
        end
    end

    always_ff @(posedge SERIAL_CLK) begin
        casc_mem[rise_bin_r] <= SERIAL_SELECT_OR_CASCADE_IN;
    end

    // Crossings into the main clock
    logic start_q;
    logic sel_in_q;
    logic sclk_q;
    logic [CNT_W-1:0] fall_g_q;
    logic [CNT_W-1:0] rise_g_q;

    asm_sync #(.W(3)) u_sync_lvl (
        .clk(MCLK),
        .rst_n(RSTN),
        .ce(CE),
        .d({CONVERSION_START_INPUT, SERIAL_SELECT_OR_CASCADE_IN, SERIAL_CLK}),
        .q({start_q, sel_in_q, sclk_q})
    );

    asm_sync #(.W(2 * CNT_W)) u_sync_cnt (
        .clk(MCLK),
        .rst_n(RSTN),
        .ce(CE),
        .d({fall_gray_r, rise_gray_r}),
        .q({fall_g_q, rise_g_q})
    );

    // Main clock state
    asm_state_t state_r;
    asm_state_t state_nxt;
    logic start_prev_r;
    logic sel_in_prev_r;
    logic sel_prev_r;
    logic cs_mode_r;
    logic cs_mode_nxt;
    logic busy_r;
    logic busy_nxt;
    logic [CONV_CNT_W-1:0] conv_cnt_r;
    logic [CONV_CNT_W-1:0] conv_cnt_nxt;
    logic [DATA_W-1:0] word_r;
    logic [DATA_W-1:0] word_nxt;
    logic [CNT_W-1:0] fall_base_r;
    logic [CNT_W-1:0] rise_base_r;
    logic sdo_nxt;
    logic oe_n_nxt;

    wire start_rise = start_q & ~start_prev_r;
    wire conv_done = (conv_cnt_r == CONV_CNT_W'(CONV_CYCLES - 1));
    wire in_conv = (state_r == ST_CONV);
    wire in_read = (state_r == ST_READ);
    wire [CNT_W-1:0] fall_now = g2b(fall_g_q);
    wire [CNT_W-1:0] rise_now = g2b(rise_g_q);
    wire [CNT_W-1:0] busy_ext = {{(CNT_W-1){1'b0}}, busy_r};
    wire [CNT_W-1:0] k = fall_now - fall_base_r;
    wire [CNT_W-1:0] data_k = k - busy_ext;
    wire [CNT_W-1:0] total = OWN_BITS + busy_ext;
    wire sel = cs_mode_r ? (~start_q | ~sel_in_q) : ~start_q;
    wire cs_spent = cs_mode_r & (k >= total);
    wire own_phase = (data_k < OWN_BITS);
    wire [DATA_W-1:0] word_sh = word_r << data_k[4:0];
    wire [CNT_W-1:0] casc_idx = rise_base_r + (data_k - OWN_BITS);
    wire start_bit = busy_r & (k == CNT_RST);
    wire bit_sel = start_bit ? 1'b0 : (own_phase ? word_sh[DATA_W-1] : casc_mem[casc_idx]);
    wire drive = in_read & sel & ~cs_spent;
    wire busy_cs = ~start_q | ~sel_in_q;
    wire [DATA_W-1:0] code_sat = ADC_OVER ? CODE_POS_MAX : ADC_CODE;

    assign sdo_nxt = drive ? bit_sel : 1'b0;
    assign oe_n_nxt = ~drive;

    always_comb begin
        state_nxt = state_r;
        cs_mode_nxt = cs_mode_r;
        busy_nxt = busy_r;
        conv_cnt_nxt = conv_cnt_r;
        word_nxt = word_r;
        case (state_r)
            ST_IDLE, ST_READ: begin
                if (start_rise) begin
                    state_nxt = ST_CONV;
                    cs_mode_nxt = sel_in_prev_r;
                    busy_nxt = sel_in_prev_r ? 1'b0 : sclk_q;
                    conv_cnt_nxt = '0;
                end else if (in_read && sel_prev_r && !sel) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_CONV: begin
                conv_cnt_nxt = conv_cnt_r + 7'h01;
                if (conv_done) begin
                    state_nxt = ST_READ;
                    word_nxt = code_sat;
                    busy_nxt = cs_mode_r ? busy_cs : busy_r;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            state_r <= ST_IDLE;
            cs_mode_r <= 1'b0;
            busy_r <= 1'b0;
            conv_cnt_r <= '0;
            word_r <= WORD_RST;
        end else if (CE) begin
            state_r <= state_nxt;
            cs_mode_r <= cs_mode_nxt;
            busy_r <= busy_nxt;
            conv_cnt_r <= conv_cnt_nxt;
            word_r <= word_nxt;
        end
    end

    // Frame base follows the counters until the frame is selected
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            start_prev_r <= 1'b0;
            sel_in_prev_r <= 1'b0;
            sel_prev_r <= 1'b0;
            fall_base_r <= CNT_RST;
            rise_base_r <= CNT_RST;
        end else if (CE) begin
            start_prev_r <= start_q;
            sel_in_prev_r <= sel_in_q;
            sel_prev_r <= sel & in_read;
            if (!(in_read && sel)) begin
                fall_base_r <= fall_now;
                rise_base_r <= rise_now;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            SERIAL_RESULT_OUT <= 1'b0;
            SERIAL_RESULT_OE_N <= OE_N_RST;
            CONVERTING <= 1'b0;
            CS_MODE <= 1'b0;
            BUSY_EN <= 1'b0;
        end else if (CE) begin
            SERIAL_RESULT_OUT <= sdo_nxt;
            SERIAL_RESULT_OE_N <= oe_n_nxt;
            CONVERTING <= (state_nxt == ST_CONV);
            CS_MODE <= cs_mode_nxt;
            BUSY_EN <= busy_nxt;
        end
    end
endmodule : asm_readout
`default_nettype wire

// File: design/asm_sync.sv
// Three-stage input synchroniser, output follows once stages two and three agree
`default_nettype none
module asm_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    wire agree = (s2_r == s3_r);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q <= '0;
        end else if (ce) begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (agree) begin
                q <= s3_r;
            end
        end
    end
endmodule : asm_sync
`default_nettype wire

// File: include/asm_pkg.sv
// Constants and types shared by the converter serial readout block
`default_nettype none
package asm_pkg;
    localparam int DATA_W = 18;
    localparam int CNT_W = 6;
    localparam int CLK_MHZ = 125;
    localparam int CONV_TIME_NS = 500;
    localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ) / 1000;
    localparam int CONV_CNT_W = 7;
    localparam logic [DATA_W-1:0] CODE_POS_MAX = 18'h1ffff;
    localparam logic [DATA_W-1:0] WORD_RST = 18'h00000;
    localparam logic [CNT_W-1:0] CNT_RST = 6'h00;
    localparam logic [CNT_W-1:0] OWN_BITS = 6'h12;
    localparam logic OE_N_RST = 1'b1;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_READ = 3'b100
    } asm_state_t;
endpackage : asm_pkg
`default_nettype wire

// File: tb/asm_host.sv
// Host model driving start, select and serial clock
`default_nettype none
module asm_host (
    output logic start,
    output logic sel,
    output logic sck
);
    timeunit 1ns;
    timeprecision 100ps;
    logic lclk = 1'b0;
    initial begin
        start = 1'b0;
        sel = 1'b0;
        sck = 1'b0;
    end
    always #6 lclk = ~lclk;
    task automatic set(input logic c, input logic s, input logic k);
        @(posedge lclk) #1;
        start = c;
        sel = s;
        sck = k;
        repeat (10) @(posedge lclk);
    endtask : set
    task automatic tick(input logic cin);
        @(posedge lclk) #1;
        sel = cin;
        repeat (5) @(posedge lclk);
        #1 sck = 1'b1;
        repeat (5) @(posedge lclk);
        #1 sck = 1'b0;
        repeat (6) @(posedge lclk);
    endtask : tick
endmodule : asm_host
`default_nettype wire

// File: tb/asm_readout_sva.sv
// Assertions on the converter readout block ports
`default_nettype none
module asm_readout_sva (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic SERIAL_RESULT_OUT,
    input wire logic SERIAL_RESULT_OE_N,
    input wire logic CONVERTING,
    input wire logic CS_MODE,
    input wire logic BUSY_EN
);
    import asm_pkg::*;
    logic [CONV_CNT_W-1:0] cnt_r;
    logic [CONV_CNT_W-1:0] cnt_nxt;
    assign cnt_nxt = CONVERTING ? cnt_r + 1'b1 : '0;
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    sequence conv_end;
        $fell(CONVERTING);
    endsequence
    sequence cs_busy_end;
        $fell(CONVERTING) && BUSY_EN && CS_MODE;
    endsequence
    sequence busy_flag;
        ##[0:2] (!SERIAL_RESULT_OE_N && !SERIAL_RESULT_OUT);
    endsequence
    chk_conv_length: assert property (conv_end |-> cnt_r == CONV_CYCLES)
        else $error("conversion length wrong");
    chk_conv_hiz: assert property (CONVERTING && $past(CONVERTING) |-> SERIAL_RESULT_OE_N)
        else $error("output driven in conversion");
    chk_out_quiet: assert property (SERIAL_RESULT_OE_N |-> !SERIAL_RESULT_OUT)
        else $error("data while released");
    chk_mode_at_start: assert property ($changed(CS_MODE) |-> $rose(CONVERTING))
        else $error("mode changed off start");
    chk_busy_update: assert property ($changed(BUSY_EN) |-> $rose(CONVERTING) || $fell(CONVERTING))
        else $error("busy option changed mid run");
    chk_busy_drive: assert property (cs_busy_end |-> busy_flag)
        else $error("no busy low at end");
    chk_conv_gap: assert property (conv_end |=> !CONVERTING [*2])
        else $error("conversion restarted");
    chk_reset_idle: assert property (disable iff (1'b0) !RSTN |-> SERIAL_RESULT_OE_N && !CONVERTING)
        else $error("not idle in reset");
endmodule : asm_readout_sva
bind asm_readout asm_readout_sva chk_u (.MCLK(MCLK), .RSTN(RSTN), .SERIAL_RESULT_OUT(SERIAL_RESULT_OUT),
    .SERIAL_RESULT_OE_N(SERIAL_RESULT_OE_N), .CONVERTING(CONVERTING), .CS_MODE(CS_MODE), .BUSY_EN(BUSY_EN));
`default_nettype wire

// File: tb/asm_readout_test.sv
// Self-checking bench for the converter readout block
`default_nettype none
module asm_readout_test;
    timeunit 1ns;
    timeprecision 100ps;
    import asm_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b1;
    logic ce = 1'b1;
    logic [DATA_W-1:0] code = 18'h2a5c3;
    logic over = 1'b0;
    wire sck, start, sel, serial_result_out, oe_n, conv, csm, busy;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;
    always #4 mclk = ~mclk;
    asm_readout dut_u (.MCLK(mclk), .RSTN(rstn), .CE(ce), .SERIAL_CLK(sck), .CONVERSION_START_INPUT(start),
        .SERIAL_SELECT_OR_CASCADE_IN(sel), .ADC_CODE(code), .ADC_OVER(over), .SERIAL_RESULT_OUT(serial_result_out),
        .SERIAL_RESULT_OE_N(oe_n), .CONVERTING(conv), .CS_MODE(csm), .BUSY_EN(busy));
    asm_host h (.start(start), .sel(sel), .sck(sck));
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic frame(input int n, input logic [31:0] cin, input logic [31:0] e, input string nm);
        logic [31:0] w;
        w = '0;
        for (int i = 0; i < n; i++) begin
            w = {w[30:0], serial_result_out};
            h.tick(cin[31-i]);
        end
        check(nm, e, w);
    endtask : frame
    task automatic wait_conv();
        repeat (CONV_CYCLES) @(posedge mclk);
        #1;
        check("conv_end", 0, 32'(conv));
    endtask : wait_conv
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        #1 rstn = 1'b0;
        repeat (2) @(posedge mclk);
        #1 rstn = 1'b1;
        h.set(1'b0, 1'b1, 1'b0);
        h.set(1'b1, 1'b1, 1'b0);
        check("converting", 1, 32'(conv));
        wait_conv();
        check("cs_mode", 1, 32'(csm));
        check("busy_off", 0, 32'(busy));
        h.set(1'b0, 1'b1, 1'b0);
        frame(18, '1, 32'(code), "cs3_word");
        check("release", 1, 32'(oe_n));
        $display("test cs3 done");
        @(posedge mclk) #1 ce = 1'b0;
        h.set(1'b1, 1'b1, 1'b0);
        h.set(1'b0, 1'b1, 1'b0);
        @(posedge mclk) #1 ce = 1'b1;
        repeat (8) @(posedge mclk);
        #1;
        check("ce_freeze", 0, 32'(conv));
        $display("test freeze done");
        @(posedge mclk) #1 over = 1'b1;
        h.set(1'b1, 1'b1, 1'b0);
        h.set(1'b0, 1'b1, 1'b0);
        wait_conv();
        check("busy_on", 1, 32'(busy));
        check("busy_drive", 0, 32'({oe_n, serial_result_out}));
        frame(19, '1, 32'({1'b0, CODE_POS_MAX}), "cs3_busy");
        check("release19", 1, 32'(oe_n));
        $display("test busy done");
        @(posedge mclk) #1 over = 1'b0;
        h.set(1'b1, 1'b1, 1'b0);
        wait_conv();
        check("busy_4w", 0, 32'(busy));
        h.set(1'b1, 1'b0, 1'b0);
        frame(5, '0, 32'(code[17:13]), "cs4_part");
        h.set(1'b1, 1'b1, 1'b0);
        check("deselect", 1, 32'(oe_n));
        h.set(1'b0, 1'b1, 1'b0);
        h.set(1'b1, 1'b1, 1'b0);
        h.set(1'b1, 1'b0, 1'b0);
        wait_conv();
        check("busy_4w_on", 1, 32'(busy));
        check("busy_drive4", 0, 32'({oe_n, serial_result_out}));
        frame(19, '0, 32'({1'b0, code}), "cs4_busy");
        check("release4", 1, 32'(oe_n));
        $display("test cs4 done");
        h.set(1'b0, 1'b0, 1'b1);
        h.set(1'b1, 1'b0, 1'b1);
        wait_conv();
        check("chain", 0, 32'(csm));
        check("busy_chain", 1, 32'(busy));
        h.set(1'b0, 1'b0, 1'b0);
        h.set(1'b1, 1'b0, 1'b0);
        wait_conv();
        check("busy_none", 0, 32'(busy));
        h.set(1'b0, 1'b0, 1'b0);
        frame(22, 32'hb0000000, 32'({code, 4'hb}), "chain");
        $display("test chain done");
        h.set(1'b1, 1'b1, 1'b0);
        wait_conv();
        check("tied", 0, 32'(csm));
        $display("test tied done");
        conclude();
    end
endmodule : asm_readout_test
`default_nettype wire
